// >>> adc_config_and_sequencing.v
// converter control: wishbone registers, sequencing, references and pins
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
module adc_config_and_sequencing
#(
    parameter RES_BITS  = 10,
    parameter CHANNELS  = 16
)
(
    // clock and reset
    input  wire                clk_i,
    input  wire                rst_n_i,
    // wishbone slave
    input  wire                cyc_i,
    input  wire                stb_i,
    input  wire                we_i,
    input  wire [7:0]          adr_i,
    input  wire [3:0]          sel_i,
    input  wire [31:0]         dat_i,
    output reg  [31:0]         dat_o,
    output reg                 ack_o,
    // analog front end
    input  wire                comp_i,
    input  wire                rc_tick_i,
    output wire [RES_BITS-1:0] sar_code_o,
    output wire                sample_o,
    output wire                powered_o,
    output wire                neg_ref_select_o,
    output wire                pos_ref_select_o,
    output wire [CHANNELS-1:0] pin_analog_o,
    // interrupt
    output wire                irq_o
);
    // ********************************************************
    // state codes
    // ********************************************************
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ACQ  = 2'd1;
    localparam [1:0] ST_CONV = 2'd2;
    localparam [1:0] ST_HOLD = 2'd3;

    // ********************************************************
    // registers
    // ********************************************************
    reg  [7:0]          control;
    reg  [7:0]          pin_ref_cfg;
    reg  [7:0]          time_fmt_cfg;
    reg  [7:0]          result_high;
    reg  [7:0]          result_low;
    reg  [7:0]          irq_status;
    reg  [7:0]          irq_mask;
    reg  [1:0]          state;
    reg  [4:0]          tad_cnt;
    reg  [4:0]          acq_tads;
    reg  [7:0]          next_dat;

    wire                converter_on  = control[`BIT_CONVERTER_ON];
    wire                go_busy       = control[`BIT_GO_BUSY];
    wire [3:0]          pin_analog_split = pin_ref_cfg[3:0];
    wire                result_justify =
                            time_fmt_cfg[`BIT_RESULT_JUSTIFY];
    wire [2:0]          sample_time_select = time_fmt_cfg[5:3];
    wire [2:0]          conv_clock_select  = time_fmt_cfg[2:0];

    wire                bus_req  = cyc_i && stb_i;
    wire                wr_take  = bus_req && we_i && ack_o && sel_i[0];
    wire                rd_take  = bus_req && !we_i && ack_o;
    wire [7:0]          wdata    = dat_i[7:0];

    wire                tad_tick;
    wire                sar_busy;
    wire                sar_done;
    wire [RES_BITS-1:0] sar_result;
    wire                clock_run = converter_on && (state != ST_IDLE);
    wire                ctl_wr    = wr_take && (adr_i == `OFS_CONTROL);
    wire                abort     = !converter_on
                                    || (ctl_wr
                                        && !wdata[`BIT_GO_BUSY]);
    wire                sar_start = (state == ST_CONV) && !sar_busy
                                    && !sar_done;

    // ********************************************************
    // reference and pin steering
    // ********************************************************
    assign neg_ref_select_o = pin_ref_cfg[`BIT_NEG_REF_SELECT];
    assign pos_ref_select_o = pin_ref_cfg[`BIT_POS_REF_SELECT];
    assign powered_o        = converter_on;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_pin
            // code n above zero hands the top n+1 channels to digital
            // use; the first step frees two, channel 0 goes last
            assign pin_analog_o[ch] = (pin_analog_split == 4'h0)
                || ({1'b0, pin_analog_split} + 5'h01 < CHANNELS - ch);
        end
    endgenerate

    // sampling whenever powered and no conversion holds the capacitor
    assign sample_o = converter_on && (state != ST_CONV);
    assign irq_o    = |(irq_status & irq_mask);

    // ********************************************************
    // acquisition length decode
    // ********************************************************
    always @*
    begin
        case (sample_time_select)
            3'b000:  acq_tads = 5'd0;
            3'b001:  acq_tads = 5'd2;
            3'b010:  acq_tads = 5'd4;
            3'b011:  acq_tads = 5'd6;
            3'b100:  acq_tads = 5'd8;
            3'b101:  acq_tads = 5'd12;
            3'b110:  acq_tads = 5'd16;
            default: acq_tads = 5'd20;
        endcase
    end

    // ********************************************************
    // sub blocks
    // ********************************************************
    conv_clock_gen i_conv_clock_gen
    (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (clock_run),
        .clk_sel_i  (conv_clock_select),
        .rc_tick_i  (rc_tick_i),
        .tad_tick_o (tad_tick)
    );

    sar_engine #(.RES_BITS(RES_BITS)) i_sar_engine
    (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (sar_start),
        .abort_i    (abort),
        .tad_tick_i (tad_tick),
        .comp_i     (comp_i),
        .busy_o     (sar_busy),
        .done_o     (sar_done),
        .code_o     (sar_code_o),
        .result_o   (sar_result)
    );

    // ********************************************************
    // sequencer
    // ********************************************************
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state   <= ST_IDLE;
            tad_cnt <= 5'd0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    tad_cnt <= 5'd0;
                    if (go_busy && converter_on)
                    begin
                        if (acq_tads == 5'd0)
                            state <= ST_CONV;
                        else
                            state <= ST_ACQ;
                    end
                end
                ST_ACQ:
                begin
                    if (abort)
                        state <= ST_HOLD;
                    else if (tad_tick)
                    begin
                        if (tad_cnt == acq_tads - 5'd1)
                        begin
                            tad_cnt <= 5'd0;
                            state   <= ST_CONV;
                        end
                        else
                            tad_cnt <= tad_cnt + 5'd1;
                    end
                end
                ST_CONV:
                begin
                    tad_cnt <= 5'd0;
                    if (abort || sar_done)
                        state <= ST_HOLD;
                end
                default:
                begin
                    // the hold-off also follows an abort, and a new start
                    // waits here until it is over
                    if (!converter_on)
                    begin
                        state   <= ST_IDLE;
                        tad_cnt <= 5'd0;
                    end
                    else if (tad_tick)
                    begin
                        if (tad_cnt == `HOLDOFF_TADS - 1)
                        begin
                            tad_cnt <= 5'd0;
                            state   <= ST_IDLE;
                        end
                        else
                            tad_cnt <= tad_cnt + 5'd1;
                    end
                end
            endcase
        end
    end

    // ********************************************************
    // control and configuration registers
    // ********************************************************
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            control      <= `RST_CONTROL;
            pin_ref_cfg  <= `RST_PIN_REF_CFG;
            time_fmt_cfg <= `RST_TIME_FMT_CFG;
            irq_mask     <= `RST_IRQ;
        end
        else
        begin
            if (ctl_wr)
            begin
                control[`BIT_CONVERTER_ON] <= wdata[`BIT_CONVERTER_ON];
                // start only takes while the converter is powered
                control[`BIT_GO_BUSY] <= wdata[`BIT_GO_BUSY]
                                         && wdata[`BIT_CONVERTER_ON];
            end
            else if (sar_done || !converter_on)
                control[`BIT_GO_BUSY] <= 1'b0;
            if (wr_take && adr_i == `OFS_PIN_REF_CFG)
                pin_ref_cfg <= wdata & `MSK_PIN_REF_CFG;
            if (wr_take && adr_i == `OFS_TIME_FMT_CFG)
                time_fmt_cfg <= wdata & `MSK_TIME_FMT_CFG;
            if (wr_take && adr_i == `OFS_IRQ_MASK)
                irq_mask <= wdata & `MSK_IRQ;
        end
    end

    // ********************************************************
    // interrupt status: set wins over read-clear
    // ********************************************************
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_status <= `RST_IRQ;
        else if (sar_done && !abort)
            irq_status[`BIT_CONV_DONE] <= 1'b1;
        else if (rd_take && adr_i == `OFS_IRQ_STATUS)
            irq_status <= `RST_IRQ;
    end

    // ********************************************************
    // result pair: no reset, power-up content is undefined
    // ********************************************************
    always @(posedge clk_i)
    begin
        if (sar_done && !abort)
        begin
            if (result_justify)
            begin
                result_high <= {6'h00, sar_result[9:8]};
                result_low  <= sar_result[7:0];
            end
            else
            begin
                result_high <= sar_result[9:2];
                result_low  <= {sar_result[1:0], 6'h00};
            end
        end
        else
        begin
            // software may preload the pair; an abort leaves it alone
            if (wr_take && adr_i == `OFS_RESULT_HIGH)
                result_high <= wdata;
            if (wr_take && adr_i == `OFS_RESULT_LOW)
                result_low <= wdata;
        end
    end

    // ********************************************************
    // bus read mux and acknowledge
    // ********************************************************
    always @*
    begin
        if (adr_i == `OFS_CONTROL)
            next_dat = control & `MSK_CONTROL;
        else if (adr_i == `OFS_PIN_REF_CFG)
            next_dat = pin_ref_cfg;
        else if (adr_i == `OFS_TIME_FMT_CFG)
            next_dat = time_fmt_cfg;
        else if (adr_i == `OFS_RESULT_HIGH)
            next_dat = result_high;
        else if (adr_i == `OFS_RESULT_LOW)
            next_dat = result_low;
        else if (adr_i == `OFS_IRQ_STATUS)
            next_dat = irq_status;
        else if (adr_i == `OFS_IRQ_MASK)
            next_dat = irq_mask;
        else
            next_dat = 8'h00;
    end

    // one wait state: data is latched with the request, ack follows
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= bus_req && !ack_o;
            if (bus_req && !ack_o)
                dat_o <= {24'h00_0000, next_dat};
        end
    end
endmodule // adc_config_and_sequencing
`default_nettype wire

// >>> adc_ctrl_map.vh
// register map, field positions, reset values and timing counts of the converter control
// Behaviour
// - bit 5 picks negative reference pin or ground
// - bit 4 picks positive reference pin or supply
// - split field turns top channels digital stepwise
// - format bit 7: 1 right, 0 left justify
// - sample time codes give 0..20 clock periods
// - clock select: divide 2,8,32,4,16,64 or RC
// - RC clock starts one instruction cycle late
// - completion loads result, clears busy, sets flag
// - reset clears registers, powers off, aborts conversion
// - result pair is never initialised by reset
// - programmed sample time precedes conversion after start
// - two clock periods hold-off after each conversion
// - unimplemented config bits ignore writes, read zero
// - busy at bit 1, enable at bit 0
// - a conversion lasts eleven clock periods
// - clearing busy aborts, result pair keeps old value
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// ********************************************************
// byte offsets on the register bus
// ********************************************************
`define OFS_CONTROL      8'h00
`define OFS_PIN_REF_CFG  8'h04
`define OFS_TIME_FMT_CFG 8'h08
`define OFS_RESULT_HIGH  8'h0c
`define OFS_RESULT_LOW   8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_MASK     8'h18

// ********************************************************
// field positions
// ********************************************************
`define BIT_CONVERTER_ON   0
`define BIT_GO_BUSY        1
`define BIT_NEG_REF_SELECT 5
`define BIT_POS_REF_SELECT 4
`define BIT_RESULT_JUSTIFY 7
`define BIT_CONV_DONE      0
`define MSK_PIN_REF_CFG    8'h3f
`define MSK_TIME_FMT_CFG   8'hbf
`define MSK_CONTROL        8'h03
`define MSK_IRQ            8'h01

// ********************************************************
// reset values
// ********************************************************
`define RST_CONTROL      8'h00
`define RST_PIN_REF_CFG  8'h00
`define RST_TIME_FMT_CFG 8'h00
`define RST_IRQ          8'h00

// ********************************************************
// timing counts
// ********************************************************
`define CLK_PERIOD_NS   10
`define TCY_FOSC_PERIODS 4
`define TCY_CLKS        (`TCY_FOSC_PERIODS)
`define CONV_TADS       11
`define HOLDOFF_TADS    2

`endif

// >>> conv_clock_gen.v
// conversion clock tick generator: oscillator divider or delayed rc clock
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
module conv_clock_gen
(
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // control
    input  wire       run_i,
    input  wire [2:0] clk_sel_i,
    input  wire       rc_tick_i,
    // tick out, one per conversion clock period
    output reg        tad_tick_o
);
    reg  [6:0] div_cnt;
    reg  [7:0] rc_wait;
    reg        run_d;
    reg  [6:0] div_last;
    wire       rc_sel = (clk_sel_i[1:0] == 2'b11);

    always @*
    begin
        case (clk_sel_i)
            3'b000:  div_last = 7'h01;
            3'b001:  div_last = 7'h07;
            3'b010:  div_last = 7'h1f;
            3'b100:  div_last = 7'h03;
            3'b101:  div_last = 7'h0f;
            3'b110:  div_last = 7'h3f;
            default: div_last = 7'h01;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (!rst_n_i || !run_i)
        begin
            div_cnt    <= 7'h00;
            rc_wait    <= 8'h00;
            run_d      <= 1'b0;
            tad_tick_o <= 1'b0;
        end
        else
        begin
            run_d <= 1'b1;
            if (rc_sel)
            begin
                // rc clock is held back one instruction cycle after start
                if (!run_d)
                    rc_wait <= 8'h00;
                else if (rc_wait < `TCY_CLKS)
                    rc_wait <= rc_wait + 8'h01;
                tad_tick_o <= run_d && (rc_wait >= `TCY_CLKS) && rc_tick_i;
            end
            else if (div_cnt >= div_last)
            begin
                div_cnt    <= 7'h00;
                tad_tick_o <= 1'b1;
            end
            else
            begin
                div_cnt    <= div_cnt + 7'h01;
                tad_tick_o <= 1'b0;
            end
        end
    end
endmodule // conv_clock_gen
`default_nettype wire

// >>> sar_engine.v
// successive approximation sequencer, one trial bit per conversion clock
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
module sar_engine
#(
    parameter RES_BITS = 10
)
(
    // clock and reset
    input  wire                clk_i,
    input  wire                rst_n_i,
    // sequencing
    input  wire                start_i,
    input  wire                abort_i,
    input  wire                tad_tick_i,
    input  wire                comp_i,
    // results
    output reg                 busy_o,
    output reg                 done_o,
    output reg  [RES_BITS-1:0] code_o,
    output reg  [RES_BITS-1:0] result_o
);
    reg [RES_BITS-1:0] trial;
    reg [3:0]          step;

    always @(posedge clk_i)
    begin
        if (!rst_n_i || abort_i)
        begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            step   <= 4'h0;
            trial  <= {RES_BITS{1'b0}};
            code_o <= {RES_BITS{1'b0}};
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_o)
            begin
                busy_o <= 1'b1;
                step   <= 4'h0;
            end
            else if (busy_o && tad_tick_i)
            begin
                // first period settles, then one bit per period
                step <= step + 4'h1;
                if (step == 4'h0)
                begin
                    trial  <= {1'b1, {(RES_BITS-1){1'b0}}};
                    code_o <= {1'b1, {(RES_BITS-1){1'b0}}};
                end
                else
                begin
                    trial  <= trial >> 1;
                    code_o <= (comp_i ? code_o : (code_o & ~trial))
                              | (trial >> 1);
                    if (step == `CONV_TADS - 1)
                    begin
                        busy_o   <= 1'b0;
                        done_o   <= 1'b1;
                        result_o <= comp_i ? code_o : (code_o & ~trial);
                    end
                end
            end
        end
    end
endmodule // sar_engine
`default_nettype wire

// >>> adc_ctrl_chk.sv
// port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_chk
#(
    parameter RES_BITS = 10,
    parameter CHANNELS = 16
)
(
    // clock, reset and bus
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic                cyc_i,
    input wire logic                stb_i,
    input wire logic                we_i,
    input wire logic [7:0]          adr_i,
    input wire logic [3:0]          sel_i,
    input wire logic [31:0]         dat_i,
    input wire logic [31:0]         dat_o,
    input wire logic                ack_o,
    // front end and interrupt
    input wire logic                comp_i,
    input wire logic                rc_tick_i,
    input wire logic [RES_BITS-1:0] sar_code_o,
    input wire logic                sample_o,
    input wire logic                powered_o,
    input wire logic                neg_ref_select_o,
    input wire logic                pos_ref_select_o,
    input wire logic [CHANNELS-1:0] pin_analog_o,
    input wire logic                irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    wire rd = cyc_i && stb_i && !we_i && ack_o;
    // code n above zero leaves n+1 top channels digital
    function automatic logic [CHANNELS-1:0] split(input logic [3:0] c);
        return (c == 4'h0) ? {CHANNELS{1'b1}} : {CHANNELS{1'b1}} >> (c + 5'h1);
    endfunction
    property p_neg; wr && adr_i == 8'h04 |=> neg_ref_select_o == $past(dat_i[5]);
    endproperty
    a_neg: assert property (p_neg) else $error("neg reference bad");
    property p_pos; wr && adr_i == 8'h04 |=> pos_ref_select_o == $past(dat_i[4]);
    endproperty
    a_pos: assert property (p_pos) else $error("pos reference bad");
    property p_split;
        wr && adr_i == 8'h04 |=> pin_analog_o == split($past(dat_i[3:0]));
    endproperty
    a_split: assert property (p_split) else $error("pin split bad");
    property p_on; wr && adr_i == 8'h00 |=> powered_o == $past(dat_i[0]);
    endproperty
    a_on: assert property (p_on) else $error("power bit bad");
    property p_rst;
        disable iff (1'b0) !rst_n_i |=> !powered_o && !irq_o && !ack_o
            && !neg_ref_select_o && pin_analog_o == {CHANNELS{1'b1}};
    endproperty
    a_rst: assert property (p_rst) else $error("reset state bad");
    property p_cfg; rd && adr_i == 8'h04 |-> dat_o[31:6] == 26'h0; endproperty
    a_cfg: assert property (p_cfg) else $error("pin cfg spare bits");
    property p_fmt;
        rd && adr_i == 8'h08 |-> dat_o[31:8] == 24'h0 && !dat_o[6];
    endproperty
    a_fmt: assert property (p_fmt) else $error("fmt cfg spare bit");
    // once off for a cycle the trial code is parked at zero as well
    property p_off;
        !powered_o && $past(!powered_o) |-> !sample_o && sar_code_o == '0;
    endproperty
    a_off: assert property (p_off) else $error("sampling while off");
    property p_ack; $rose(cyc_i && stb_i) |=> ack_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing bad");
    c_irq: cover property ($rose(irq_o));
    c_go: cover property (wr && adr_i == 8'h00 && dat_i[1:0] == 2'h3);
    c_cfg: cover property (wr && adr_i == 8'h08);
endmodule // adc_ctrl_chk
`default_nettype wire

// >>> tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i, rst_n_i, cyc_i, stb_i, we_i, comp_i, rc_tick_i;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, q;
    logic [9:0]  target, last;
    wire  [31:0] dat_o;
    wire  [9:0]  sar_code_o;
    wire  [15:0] pin_analog_o;
    wire         ack_o, sample_o, powered_o, neg_o, pos_o, irq_o;
    int          bad_count, total_checks, rc_cnt, k;
    int divs[8] = '{2, 8, 32, 6, 4, 16, 64, 6};
    int acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    adc_config_and_sequencing i_adc_config_and_sequencing
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .comp_i(comp_i),
        .rc_tick_i(rc_tick_i), .sar_code_o(sar_code_o),
        .sample_o(sample_o), .powered_o(powered_o),
        .neg_ref_select_o(neg_o), .pos_ref_select_o(pos_o),
        .pin_analog_o(pin_analog_o), .irq_o(irq_o)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // comparator of an ideal input at target; rc clock every 6 cycles
    always @(posedge clk_i)
    begin
        comp_i <= (target >= sar_code_o);
        rc_cnt <= (rc_cnt == 5) ? 0 : rc_cnt + 1;
        rc_tick_i <= (rc_cnt == 5);
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle; returns at the negedge after the ack edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'h1;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do @(posedge clk_i); while (ack_o !== 1'b1 && n++ < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(negedge clk_i);
        chk("bus ack", 32'h1, {31'h0, n < 20});
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task t_reset;
        rd(8'h00, 32'h0, "control");
        rd(8'h04, 32'h0, "pin cfg");
        rd(8'h08, 32'h0, "time cfg");
        rd(8'h18, 32'h0, "mask");
        rd(8'h1c, 32'h0, "unmapped");
        chk("pins", 32'hffff, pin_analog_o);
    endtask
    task t_cfg;
        int c;
        wb(1'b1, 8'h04, 32'hff);
        rd(8'h04, 32'h3f, "pin cfg");
        chk("refs", 32'h3, {neg_o, pos_o});
        wb(1'b1, 8'h08, 32'hff);
        rd(8'h08, 32'hbf, "time cfg");
        for (c = 0; c < 16; c++)
        begin
            wb(1'b1, 8'h04, c);
            chk("split", c == 0 ? 32'hffff : 32'hffff >> (c + 1), pin_analog_o);
        end
        chk("refs", 32'h0, {neg_o, pos_o});
    endtask
    // conversion with sample code i, clock code i, format i[0]
    task t_conv(input int i);
        int n, lo;
        target = 10'(32'h2a5 ^ (i * 73));
        repeat (130) @(negedge clk_i);
        wb(1'b1, 8'h08, {24'h0, i[0], 1'b0, i[2:0], i[2:0]});
        wb(1'b1, 8'h00, 32'h3);
        n = 0;
        while (irq_o !== 1'b1 && n < 3000)
        begin
            @(negedge clk_i);
            n++;
        end
        lo = (acqs[i] + 11) * divs[i];
        chk("conv time", 32'h1, {31'h0, n >= lo - 2 && n <= lo + 2 * divs[i] + 12});
        rd(8'h00, 32'h1, "busy");
        rd(8'h0c, i[0] ? {30'h0, target[9:8]} : {24'h0, target[9:2]}, "res hi");
        rd(8'h10, i[0] ? {24'h0, target[7:0]} : {24'h0, target[1:0], 6'h0}, "res lo");
        rd(8'h14, 32'h1, "status");
        chk("irq clear", 32'h0, irq_o);
        chk("sampling again", 32'h1, sample_o);
    endtask
    task t_abort;
        last = target;
        target = ~target;
        wb(1'b1, 8'h18, 32'h0);
        wb(1'b1, 8'h08, 32'h06);
        wb(1'b1, 8'h00, 32'h3);
        repeat (200) @(negedge clk_i);
        chk("sampling in conv", 32'h0, sample_o);
        rd(8'h00, 32'h3, "busy set");
        wb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 32'h1, "abort busy");
        rd(8'h0c, {30'h0, last[9:8]}, "kept hi");
        rd(8'h10, {24'h0, last[7:0]}, "kept lo");
        rd(8'h14, 32'h0, "abort status");
        wb(1'b1, 8'h08, 32'h0);
        repeat (140) @(negedge clk_i);
        wb(1'b1, 8'h00, 32'h3);
        repeat (100) @(negedge clk_i);
        chk("masked irq", 32'h0, irq_o);
        rd(8'h14, 32'h1, "status");
        rd(8'h14, 32'h0, "status read clear");
    endtask
    task t_reset_mid;
        wb(1'b1, 8'h08, 32'h06);
        wb(1'b1, 8'h00, 32'h3);
        repeat (50) @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk("off after reset", 32'h0, powered_o);
        chk("no sampling", 32'h0, sample_o);
        rd(8'h00, 32'h0, "control");
        rd(8'h08, 32'h0, "time cfg");
        rd(8'h10, {24'h0, target[1:0], 6'h0}, "res kept");
        wb(1'b1, 8'h0c, 32'h5a);
        rd(8'h0c, 32'h5a, "res written");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        {rst_n_i, cyc_i, stb_i, we_i} = 4'h0;
        {adr_i, dat_i, target} = 50'h0;
        sel_i = 4'h1;
        bad_count = 0;
        total_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_cfg;
        wb(1'b1, 8'h18, 32'h1);
        for (k = 0; k < 8; k++)
            t_conv(k); // codes 3 and 7 run from the rc clock
        t_abort;
        t_reset_mid;
        wrap_up;
    end
    // bench runs about 5000 cycles
    initial
    begin
        #400000;
        bad_count++;
        wrap_up;
    end
endmodule // tb
bind adc_config_and_sequencing adc_ctrl_chk
#(.RES_BITS(RES_BITS), .CHANNELS(CHANNELS)) i_adc_ctrl_chk
(
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .comp_i(comp_i), .rc_tick_i(rc_tick_i),
    .sar_code_o(sar_code_o), .sample_o(sample_o), .powered_o(powered_o),
    .neg_ref_select_o(neg_ref_select_o),
    .pos_ref_select_o(pos_ref_select_o),
    .pin_analog_o(pin_analog_o), .irq_o(irq_o)
);
`default_nettype wire
